// File: rtl/request_packet_decoder_defs.vh
// Constants for the request packet decoder
`ifndef REQUEST_PACKET_DECODER_DEFS_VH
`define REQUEST_PACKET_DECODER_DEFS_VH
// APB register byte offsets
`define RPD_CTRL_OFF       12'h000
`define RPD_STAT_OFF       12'h004
`define RPD_ADDR_LO_OFF    12'h008
`define RPD_ADDR_HI_OFF    12'h00C
`define RPD_CMD_OFF        12'h010
`define RPD_MASK_OFF       12'h014
`define RPD_HOLD_LO_OFF    12'h018
`define RPD_HOLD_HI_OFF    12'h01C
// Command code field values
`define CMD_READ           4'h0
`define CMD_SEQ_WRITE      4'h4
`define CMD_REG_READ       4'h6
`define CMD_REG_WRITE      4'h7
`define CMD_RAND_WRITE     4'h8
`define CMD_RAND_WRITE_BM  4'hC
`define CMD_BCAST_WRITE    4'hF
// Command extension values
`define EXT_NONE           2'h0
`define EXT_HELD_MASK      2'h1
`define EXT_PACKET_MASK    2'h2
`define EXT_HELD_DATA      2'h3
// Decoded kinds
`define KIND_RESERVED      4'h0
`define KIND_SEQ_READ      4'h1
`define KIND_RAND_READ     4'h2
`define KIND_REG_READ      4'h3
`define KIND_REG_WRITE     4'h4
`define KIND_BCAST_WRITE   4'h5
`define KIND_SEQ_WRITE     4'h6
`define KIND_RAND_WRITE    4'h7
`define KIND_RAND_WRITE_BM 4'h8
// Acknowledge codes
`define ACK_NONE           2'h0
`define ACK_OKAY           2'h1
`define ACK_RETRY          2'h2
// Ticks in a request packet
`define REQ_TICKS          3'h6
`define ID_WIDTH           8
`endif

// File: rtl/request_packet_decoder.v
// Request packet framer and command decoder with APB status and control
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// Behaviour
// - Cycles 0-1 carry start, command, address bits
// - Cycles 2-5 carry extension, count, spare, address
// - Frame only when idle and not awaiting acknowledge
// - Decode reads, register read/write, broadcast write
// - Write codes take extension as mask type
// - Unmasked write leaves holding register untouched
// - Held-mask write uses holding register as mask
// - Held-data write uses holding register as data
// - Packet mask loads holding register; masks counted
// - Byte-mask octbytes come beyond counted data
// - Sequential ascending; random addresses from serial
// - Access needs identity match with base register
// - Broadcast write ignores identity match
// - Register commands move one quadbyte, address 35:2
// - Memory address 35:3, count 7:3 plus one
// - First mask enables from address 2:0 upward
// - Last mask enables up to count 2:0
// - Write masks first, last; single octbyte ANDs
// - Reads ignore the byte masks
// - Acknowledge okay or retry; broadcast never okay
// - First random low address from request bits 10:3
`include "request_packet_decoder_defs.vh"
module request_packet_decoder #(
  parameter ID_WIDTH = `ID_WIDTH
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Channel pins, sampled from the link domain
  input  wire        rx_clk,
  input  wire        channel_control_line,
  input  wire [8:0]  channel_data_lines,
  input  wire        channel_enable_line,
  // Core side: decoded request
  input  wire        core_busy,
  input  wire        ack_done,
  output reg         req_valid,
  output reg  [3:0]  req_kind,
  output reg  [35:0] req_addr,
  output reg  [7:0]  req_count,
  output reg  [5:0]  octbyte_total,
  output reg  [7:0]  first_octbyte_lane_mask,
  output reg  [7:0]  last_octbyte_lane_mask,
  output reg  [7:0]  single_octbyte_lane_mask,
  output reg  [1:0]  mask_source,
  output reg  [1:0]  data_source,
  output reg         hold_load,
  output reg         sequential_access,
  output reg         serial_addr_used,
  output reg         access_enable,
  output reg  [1:0]  ack_code,
  output reg  [7:0]  serial_low_address,
  output reg         serial_addr_valid
);

  // Three-stage samplers; second and third agree before a change counts
  reg [2:0]  clk_s_r;
  reg [2:0]  ctl_s_r;
  reg [2:0]  en_s_r;
  reg [26:0] dat_s_r;
  reg        clk_q_r;
  reg        ctl_q_r;
  reg        en_q_r;
  reg [8:0]  dat_q_r;
  wire       clk_rise;
  wire       clk_fall;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      clk_s_r <= 3'h0;
      ctl_s_r <= 3'h0;
      en_s_r  <= 3'h0;
      dat_s_r <= 27'h000_0000;
      clk_q_r <= 1'b0;
      ctl_q_r <= 1'b0;
      en_q_r  <= 1'b0;
      dat_q_r <= 9'h000;
    end
    else
    begin
      clk_s_r <= {clk_s_r[1:0], rx_clk};
      ctl_s_r <= {ctl_s_r[1:0], channel_control_line};
      en_s_r  <= {en_s_r[1:0], channel_enable_line};
      dat_s_r <= {dat_s_r[17:0], channel_data_lines};
      if (clk_s_r[1] == clk_s_r[2])
        clk_q_r <= clk_s_r[2];
      if (ctl_s_r[1] == ctl_s_r[2])
        ctl_q_r <= ctl_s_r[2];
      if (en_s_r[1] == en_s_r[2])
        en_q_r <= en_s_r[2];
      if (dat_s_r[17:9] == dat_s_r[26:18])
        dat_q_r <= dat_s_r[26:18];
    end
  end

  // Rising edge is the even tick, falling edge the odd tick.
  // Data is taken from the agreed copy, which lags the pins by a fixed delay.
  assign clk_rise = (clk_s_r[1] == clk_s_r[2]) && clk_s_r[2] && !clk_q_r;
  assign clk_fall = (clk_s_r[1] == clk_s_r[2]) && !clk_s_r[2] && clk_q_r;
  wire tick = clk_rise | clk_fall;

  // Lane mask helpers
  function [7:0] first_mask;
    input [2:0] a;
    begin
      first_mask = 8'hFF << a;
    end
  endfunction

  function [7:0] last_mask;
    input [2:0] c;
    begin
      last_mask = 8'hFF >> (3'h7 - c);
    end
  endfunction

  // Registers
  reg [ID_WIDTH-1:0] base_id_r;
  reg                enable_r;
  reg [63:0]         mask_data_holding_register;
  reg [31:0]         frame_cnt_r;
  reg [31:0]         reserved_cnt_r;

  // Framing state
  localparam ST_IDLE  = 2'h0;
  localparam ST_FRAME = 2'h1;
  localparam ST_ACK   = 2'h2;
  reg [1:0]  state_r;
  reg [2:0]  tick_r;
  reg [53:0] pkt_r;  // five ticks of control plus data, control in bit 9 of each
  reg [7:0]  sa_shift_r;
  reg [2:0]  sa_cnt_r;

  // Field extraction from the six collected ticks
  wire [9:0] t0 = pkt_r[9:0];
  wire [9:0] t1 = pkt_r[19:10];
  wire [9:0] t2 = pkt_r[29:20];
  wire [9:0] t3 = pkt_r[39:30];
  wire [9:0] t4 = pkt_r[49:40];
  wire [9:0] t5 = {ctl_q_r, dat_q_r};
  wire [3:0]  command_code_field      = {t1[8], t3[9], t1[9], t0[8]};
  wire [1:0]  command_extension_field = {t2[9], t4[9]};
  wire [35:0] f_addr  = {t3[8:0], t2[8:0], t1[7:0], t0[7:0], t5[1:0]};
  wire [7:0]  f_count = {t5[6], t4[6], t5[5], t4[5], t5[4], t4[4], t5[3:2]};
  wire [8:0]  request_spare_bits = {t5[9:7], t4[8:7], t4[3:0]};
  wire        device_select_hit  = (f_addr[35:36-ID_WIDTH] == base_id_r);

  reg [3:0] kind_c;
  always @*
  begin
    kind_c = `KIND_RESERVED;
    case (command_code_field)
      `CMD_READ:
        if (command_extension_field == `EXT_NONE)
          kind_c = `KIND_SEQ_READ;
        else if (command_extension_field == `EXT_HELD_MASK)
          kind_c = `KIND_RAND_READ;
      `CMD_REG_READ:
        if (command_extension_field == `EXT_NONE)
          kind_c = `KIND_REG_READ;
      `CMD_REG_WRITE:
        if (command_extension_field == `EXT_NONE)
          kind_c = `KIND_REG_WRITE;
      `CMD_BCAST_WRITE:
        if (command_extension_field == `EXT_NONE)
          kind_c = `KIND_BCAST_WRITE;
      `CMD_SEQ_WRITE:
        kind_c = `KIND_SEQ_WRITE;
      `CMD_RAND_WRITE:
        kind_c = `KIND_RAND_WRITE;
      `CMD_RAND_WRITE_BM:
        if (command_extension_field != `EXT_PACKET_MASK)
          kind_c = `KIND_RAND_WRITE_BM;
      default:
        kind_c = `KIND_RESERVED;
    endcase
  end

  wire is_write = (kind_c == `KIND_SEQ_WRITE) || (kind_c == `KIND_RAND_WRITE) ||
                  (kind_c == `KIND_RAND_WRITE_BM);
  wire is_reg   = (kind_c == `KIND_REG_READ) || (kind_c == `KIND_REG_WRITE) ||
                  (kind_c == `KIND_BCAST_WRITE);
  wire is_rand  = (kind_c == `KIND_RAND_READ) || (kind_c == `KIND_RAND_WRITE) ||
                  (kind_c == `KIND_RAND_WRITE_BM);
  wire selected = (kind_c == `KIND_BCAST_WRITE) || device_select_hit;
  wire do_access = enable_r && (kind_c != `KIND_RESERVED) && selected;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      tick_r <= 3'h0;
      pkt_r <= 54'h0;
      req_valid <= 1'b0;
      req_kind <= `KIND_RESERVED;
      req_addr <= 36'h0;
      req_count <= 8'h00;
      octbyte_total <= 6'h00;
      first_octbyte_lane_mask <= 8'h00;
      last_octbyte_lane_mask <= 8'h00;
      single_octbyte_lane_mask <= 8'h00;
      mask_source <= `EXT_NONE;
      data_source <= `EXT_NONE;
      hold_load <= 1'b0;
      sequential_access <= 1'b0;
      serial_addr_used <= 1'b0;
      access_enable <= 1'b0;
      ack_code <= `ACK_NONE;
      frame_cnt_r <= 32'h0000_0000;
      reserved_cnt_r <= 32'h0000_0000;
      sa_shift_r <= 8'h00;
      sa_cnt_r <= 3'h0;
      serial_low_address <= 8'h00;
      serial_addr_valid <= 1'b0;
    end
    else
    begin
      req_valid <= 1'b0;
      serial_addr_valid <= 1'b0;
      case (state_r)
        ST_IDLE:
          // Start bit is seen on an even tick only
          if (clk_rise && ctl_q_r)
          begin
            pkt_r <= {44'h0, ctl_q_r, dat_q_r};
            tick_r <= 3'h1;
            state_r <= ST_FRAME;
          end
        ST_FRAME:
          if (tick)
          begin
            if (tick_r == `REQ_TICKS - 3'h1)
            begin
              req_valid <= 1'b1;
              req_kind <= kind_c;
              // register space drops bits 1:0, memory space drops 2:0
              req_addr <= is_reg ? {f_addr[35:2], 2'b00} : {f_addr[35:3], 3'b000};
              req_count <= f_count;
              octbyte_total <= is_reg ? 6'h01 :
                               (kind_c == `KIND_RAND_WRITE_BM) ? {1'b0, f_count[7:3]} + 6'h05 :
                               {1'b0, f_count[7:3]} + 6'h01;
              first_octbyte_lane_mask <= is_write ? first_mask(f_addr[2:0]) : 8'hFF;
              last_octbyte_lane_mask <= is_write ? last_mask(f_count[2:0]) : 8'hFF;
              single_octbyte_lane_mask <= is_write ?
                (first_mask(f_addr[2:0]) & last_mask(f_count[2:0])) : 8'hFF;
              // sources: mask 0 none, 1 holding register, 2 packet; data 0 packet, 1 holding register
              mask_source <= !is_write ? `EXT_NONE : command_extension_field;
              data_source <= (is_write && command_extension_field == `EXT_HELD_DATA) ?
                             2'h1 : 2'h0;
              // A retried request leaves the holding register alone
              hold_load <= is_write && command_extension_field == `EXT_PACKET_MASK && do_access && !core_busy;
              sequential_access <= (kind_c == `KIND_SEQ_WRITE) || (kind_c == `KIND_SEQ_READ);
              serial_addr_used <= is_rand;
              access_enable <= do_access && !core_busy;
              ack_code <= (!do_access) ? `ACK_NONE :
                          core_busy ? `ACK_RETRY :
                          (kind_c == `KIND_BCAST_WRITE) ? `ACK_NONE : `ACK_OKAY;
              frame_cnt_r <= frame_cnt_r + 32'h0000_0001;
              if (kind_c == `KIND_RESERVED || request_spare_bits != 9'h000)
                reserved_cnt_r <= reserved_cnt_r + 32'h0000_0001;
              sa_cnt_r <= 3'h0;
              state_r <= ST_ACK;
            end
            else
            begin
              pkt_r[tick_r*10 +: 10] <= {ctl_q_r, dat_q_r};
              tick_r <= tick_r + 3'h1;
            end
          end
        ST_ACK:
        begin
          // Serial low addresses arrive LSB first, one bit a tick
          if (tick && serial_addr_used)
          begin
            sa_shift_r <= {en_q_r, sa_shift_r[7:1]};
            sa_cnt_r <= sa_cnt_r + 3'h1;
            if (sa_cnt_r == 3'h7)
            begin
              serial_low_address <= {en_q_r, sa_shift_r[7:1]};
              serial_addr_valid <= 1'b1;
            end
          end
          if (ack_done)
          begin
            state_r <= ST_IDLE;
            access_enable <= 1'b0;
            hold_load <= 1'b0;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // APB slave, zero wait states
  wire apb_wr = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      base_id_r <= {ID_WIDTH{1'b0}};
      enable_r <= 1'b0;
      mask_data_holding_register <= 64'h0000_0000_0000_0000;
    end
    else if (apb_wr)
    begin
      case (paddr)
        `RPD_CTRL_OFF:
        begin
          enable_r <= pwdata[0];
          base_id_r <= pwdata[8 +: ID_WIDTH];
        end
        `RPD_HOLD_LO_OFF:
          mask_data_holding_register[31:0] <= pwdata;
        `RPD_HOLD_HI_OFF:
          mask_data_holding_register[63:32] <= pwdata;
        default:
          enable_r <= enable_r;
      endcase
    end
  end

  always @*
  begin
    case (paddr)
      `RPD_CTRL_OFF:
        prdata = {{(24-ID_WIDTH){1'b0}}, base_id_r, 7'h00, enable_r};
      `RPD_STAT_OFF:
        prdata = {16'h0000, reserved_cnt_r[7:0], 4'h0, access_enable, ack_code, state_r == ST_FRAME};
      `RPD_ADDR_LO_OFF:
        prdata = req_addr[31:0];
      `RPD_ADDR_HI_OFF:
        prdata = {28'h000_0000, req_addr[35:32]};
      `RPD_CMD_OFF:
        prdata = {frame_cnt_r[15:0], 2'h0, octbyte_total, req_kind, req_count[3:0]};
      `RPD_MASK_OFF:
        prdata = {8'h00, single_octbyte_lane_mask, last_octbyte_lane_mask, first_octbyte_lane_mask};
      `RPD_HOLD_LO_OFF:
        prdata = mask_data_holding_register[31:0];
      `RPD_HOLD_HI_OFF:
        prdata = mask_data_holding_register[63:32];
      default:
        prdata = 32'h0000_0000;
    endcase
  end

endmodule // request_packet_decoder

// File: test/channel_master_model.sv
// Channel initiator model that frames request packets on the link pins
`timescale 1ns/10ps
module channel_master_model (
  // Channel pins
  output reg       rx_clk,
  output reg       channel_control_line,
  output reg [8:0] channel_data_lines,
  output reg       channel_enable_line
);
  integer i;
  // Idle lines sit at the pulled-down level and the link clock stands still between frames
  initial
  begin
    rx_clk = 1'b0;
    channel_control_line = 1'b0;
    channel_data_lines = 9'h000;
    channel_enable_line = 1'b0;
  end
  // Levels change half a tick before their edge so they are settled when sampled
  task tick(input [9:0] v, input e);
  begin
    {channel_control_line, channel_data_lines} = v;
    channel_enable_line = e;
    #40;
    rx_clk = ~rx_clk;
    #40;
  end
  endtask
  task send(input [3:0] c, input [1:0] x, input [35:0] a, input [7:0] n, input [7:0] s);
  begin
    #7;
    tick({1'b1, c[0], a[9:2]}, 1'b0);
    tick({c[1], c[3], a[17:10]}, 1'b0);
    tick({x[1], a[26:18]}, 1'b0);
    tick({c[2], a[35:27]}, 1'b0);
    tick({x[0], 2'b00, n[6], n[4], n[2], 4'h0}, 1'b0);
    tick({3'b000, n[7], n[5], n[3], n[1:0], a[1:0]}, 1'b0);
    for (i = 0; i < 8; i = i + 1)
      tick(10'h000, s[i]);
    channel_enable_line = 1'b0;
  end
  endtask
endmodule  // channel_master_model

// File: test/request_packet_decoder_checker.sv
// Assertions on the decoded request outputs
`timescale 1ns/10ps
`include "request_packet_decoder_defs.vh"
module request_packet_decoder_checker (
  // Clock and reset
  input wire        core_clk,
  input wire        sys_rst,
  // Decoded request
  input wire        req_valid,
  input wire [3:0]  req_kind,
  input wire [35:0] req_addr,
  input wire [7:0]  req_count,
  input wire [5:0]  octbyte_total,
  input wire [7:0]  first_octbyte_lane_mask,
  input wire [7:0]  last_octbyte_lane_mask,
  input wire [7:0]  single_octbyte_lane_mask,
  input wire [1:0]  mask_source,
  input wire        hold_load,
  input wire        access_enable,
  input wire [1:0]  ack_code
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  wire       rd_k = req_kind == `KIND_SEQ_READ || req_kind == `KIND_RAND_READ;
  wire       bm_k = req_kind == `KIND_RAND_WRITE_BM;
  wire       wr_k = req_kind == `KIND_SEQ_WRITE || req_kind == `KIND_RAND_WRITE || bm_k;
  wire       rg_k = req_kind == `KIND_REG_READ || req_kind == `KIND_REG_WRITE || req_kind == `KIND_BCAST_WRITE;
  wire [7:0] fm   = first_octbyte_lane_mask;
  wire [7:0] lm   = last_octbyte_lane_mask;
  wire [5:0] cnt1 = {1'b0, req_count[7:3]} + 6'd1;
  chk_valid_pulse: assert property (req_valid |=> !req_valid)
    else $error("request strobe too long");
  chk_bcast_no_okay: assert property (req_valid && req_kind == `KIND_BCAST_WRITE |-> ack_code != `ACK_OKAY)
    else $error("broadcast got okay");
  chk_reserved_idle: assert property (req_valid && req_kind == `KIND_RESERVED |-> !access_enable)
    else $error("reserved command accessed");
  chk_retry_idle: assert property (req_valid && ack_code == `ACK_RETRY |-> !access_enable && !hold_load)
    else $error("retry with access");
  chk_reg_quad: assert property (req_valid && rg_k |-> octbyte_total == 6'd1 && req_addr[1:0] == 2'b00)
    else $error("register transfer size");
  chk_mem_count: assert property (req_valid && (rd_k || wr_k) |-> octbyte_total == (bm_k ? cnt1 + 6'd4 : cnt1))
    else $error("memory transfer size");
  chk_last_mask: assert property (req_valid && wr_k |-> lm == 8'hFF >> (3'd7 - req_count[2:0]))
    else $error("last mask");
  chk_first_shape: assert property (req_valid && wr_k |-> fm[7] && ((~fm) & (~fm + 8'h01)) == 8'h00)
    else $error("first mask shape");
  chk_single_and: assert property (req_valid && wr_k |-> single_octbyte_lane_mask == (fm & lm))
    else $error("single mask");
  chk_hold_source: assert property (req_valid && hold_load |-> mask_source == `EXT_PACKET_MASK && access_enable)
    else $error("holding load source");
  cover property (req_valid && bm_k);
  cover property (req_valid && ack_code == `ACK_RETRY);
  cover property (req_valid && hold_load);
endmodule  // request_packet_decoder_checker
bind request_packet_decoder request_packet_decoder_checker u_chk (.core_clk, .sys_rst, .req_valid, .req_kind,
  .req_addr, .req_count, .octbyte_total, .first_octbyte_lane_mask, .last_octbyte_lane_mask,
  .single_octbyte_lane_mask, .mask_source, .hold_load, .access_enable, .ack_code);

// File: test/request_packet_decoder_tb.sv
// Self-checking bench for the request packet decoder
`timescale 1ns/10ps
`include "request_packet_decoder_defs.vh"
module request_packet_decoder_tb;
  localparam [35:0] ADR = 36'hA_5001_204C;
  localparam [35:0] FAR = 36'h3_5001_204C;
  reg         core_clk;
  reg         sys_rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         core_busy = 1'b0;
  reg         ack_done = 1'b0;
  reg  [7:0]  serial_low_address_seen = 8'h00;
  reg  [31:0] rd;
  wire [31:0] prdata;
  wire [35:0] req_addr;
  wire [7:0]  req_count, first_octbyte_lane_mask, last_octbyte_lane_mask, single_octbyte_lane_mask;
  wire [7:0]  serial_low_address;
  wire [8:0]  channel_data_lines;
  wire [5:0]  octbyte_total;
  wire [3:0]  req_kind;
  wire [1:0]  mask_source, data_source, ack_code;
  wire        pready, pslverr, rx_clk, channel_control_line, channel_enable_line, req_valid, hold_load;
  wire        sequential_access, serial_addr_used, access_enable, serial_addr_valid;
  integer     error_cnt = 0;
  integer     checks_done = 0;
  integer     cyc = 0;
  integer     i;
  request_packet_decoder dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_clk, .channel_control_line, .channel_data_lines, .channel_enable_line, .core_busy, .ack_done,
    .req_valid, .req_kind, .req_addr, .req_count, .octbyte_total, .first_octbyte_lane_mask, .last_octbyte_lane_mask,
    .single_octbyte_lane_mask, .mask_source, .data_source, .hold_load, .sequential_access, .serial_addr_used,
    .access_enable, .ack_code, .serial_low_address, .serial_addr_valid);
  channel_master_model u_master (.rx_clk, .channel_control_line, .channel_data_lines, .channel_enable_line);
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (serial_addr_valid === 1'b1)
      serial_low_address_seen <= serial_low_address;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  task cmp(input [39:0] g, input [39:0] e, input string nm);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD %0t %s got %h exp %h", $time, nm, g, e);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task ack_pulse;
  begin
    @(posedge core_clk);
    ack_done <= 1'b1;
    @(posedge core_clk);
    ack_done <= 1'b0;
  end
  endtask
  function [3:0] ek(input [3:0] c, input [1:0] x);
    case (c)
      `CMD_READ: ek = x == 2'd0 ? `KIND_SEQ_READ : x == 2'd1 ? `KIND_RAND_READ : `KIND_RESERVED;
      `CMD_SEQ_WRITE: ek = `KIND_SEQ_WRITE;
      `CMD_REG_READ: ek = x == 2'd0 ? `KIND_REG_READ : `KIND_RESERVED;
      `CMD_REG_WRITE: ek = x == 2'd0 ? `KIND_REG_WRITE : `KIND_RESERVED;
      `CMD_RAND_WRITE: ek = `KIND_RAND_WRITE;
      `CMD_RAND_WRITE_BM: ek = x == 2'd2 ? `KIND_RESERVED : `KIND_RAND_WRITE_BM;
      `CMD_BCAST_WRITE: ek = x == 2'd0 ? `KIND_BCAST_WRITE : `KIND_RESERVED;
      default: ek = `KIND_RESERVED;
    endcase
  endfunction
  // One request end to end; the frame is only watched, the core side answers after it
  task do_req(input [3:0] c, input [1:0] x, input [35:0] a, input [7:0] n, input hit, input busy, input ack);
    reg [3:0] k;
    reg       w;
    reg       rg;
    reg       acc;
    reg       ser;
    reg [7:0] f;
    reg [7:0] l;
    integer   t;
  begin
    k = ek(c, x);
    w = k == `KIND_SEQ_WRITE || k == `KIND_RAND_WRITE || k == `KIND_RAND_WRITE_BM;
    rg = k == `KIND_REG_READ || k == `KIND_REG_WRITE || k == `KIND_BCAST_WRITE;
    acc = k != `KIND_RESERVED && !busy && (hit || k == `KIND_BCAST_WRITE);
    ser = acc && (k == `KIND_RAND_READ || k == `KIND_RAND_WRITE || k == `KIND_RAND_WRITE_BM);
    f = w ? 8'hFF << a[2:0] : 8'hFF;
    l = w ? 8'hFF >> (3'd7 - n[2:0]) : 8'hFF;
    t = 0;
    @(posedge core_clk);
    core_busy <= busy;
    serial_low_address_seen <= 8'h00;
    fork
      u_master.send(c, x, a, n, 8'h5A);
      while (req_valid !== 1'b1 && t < 300)
      begin
        @(negedge core_clk);
        t = t + 1;
      end
    join
    cmp(t < 300, 1'b1, "strobe");
    cmp(req_kind, k, "kind");
    cmp(ack_code, (!rg || k != `KIND_BCAST_WRITE) && acc ? `ACK_OKAY : busy && hit && k != `KIND_RESERVED
        && k != `KIND_BCAST_WRITE ? `ACK_RETRY : `ACK_NONE, "ack");
    cmp(access_enable, acc, "access");
    cmp(hold_load, acc && w && x == `EXT_PACKET_MASK, "hold");
    cmp(mask_source, w ? x : 2'b00, "msrc");
    cmp(data_source, w && x == `EXT_HELD_DATA, "dsrc");
    cmp(first_octbyte_lane_mask, f, "first");
    cmp(last_octbyte_lane_mask, l, "last");
    cmp(single_octbyte_lane_mask, f & l, "single");
    if (k != `KIND_RESERVED)
    begin
      cmp(octbyte_total, rg ? 6'd1 : n[7:3] + (k == `KIND_RAND_WRITE_BM ? 6'd5 : 6'd1), "total");
      cmp(req_addr, rg ? {a[35:2], 2'b00} : {a[35:3], 3'b000}, "addr");
      cmp(sequential_access, k == `KIND_SEQ_READ || k == `KIND_SEQ_WRITE, "seq");
      cmp(serial_addr_used, k == `KIND_RAND_READ || k == `KIND_RAND_WRITE || k == `KIND_RAND_WRITE_BM, "rand");
    end
    t = 0;
    while (ser && serial_low_address_seen !== 8'h5A && t < 20)
    begin
      @(negedge core_clk);
      t = t + 1;
    end
    if (ser)
      cmp(serial_low_address_seen, 8'h5A, "serial");
    if (ack)
      ack_pulse;
  end
  endtask
  task t_regs;
  begin
    apb(1'b0, `RPD_CTRL_OFF, 32'h0);
    cmp(rd, 32'h0, "ctrl reset");
    apb(1'b1, `RPD_CTRL_OFF, 32'h0000_A501);
    apb(1'b0, `RPD_CTRL_OFF, 32'h0);
    cmp(rd, 32'h0000_A501, "ctrl");
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    apb(1'b0, 12'h020, 32'h0);
    cmp(rd, 32'h0, "unmapped");
    cmp(pslverr, 1'b0, "slverr");
  end
  endtask
  // A start bit while an answer is still owed must not open a frame
  task t_refuse;
    integer t;
  begin
    do_req(`CMD_REG_READ, `EXT_NONE, ADR, 8'h00, 1'b1, 1'b0, 1'b0);
    t = 0;
    fork
      u_master.send(`CMD_READ, `EXT_NONE, ADR, 8'h1B, 8'h00);
      repeat (80)
      begin
        @(negedge core_clk);
        if (req_valid === 1'b1)
          t = t + 1;
      end
    join
    cmp(t, 0, "refused");
    ack_pulse;
  end
  endtask
  task t_masks;
  begin
    for (i = 0; i < 8; i = i + 1)
      do_req(`CMD_SEQ_WRITE, `EXT_NONE, {28'hA50_0120, 5'd9, i[2:0]}, {5'd0, i[2:0]}, 1'b1, 1'b0, 1'b1);
  end
  endtask
  task t_table;
  begin
    for (i = 0; i < 64; i = i + 1)
      do_req(i[5:2], i[1:0], ADR, 8'h1B, 1'b1, 1'b0, 1'b1);
  end
  endtask
  task t_access;
  begin
    do_req(`CMD_READ, `EXT_NONE, FAR, 8'h1B, 1'b0, 1'b0, 1'b1);
    do_req(`CMD_REG_WRITE, `EXT_NONE, FAR, 8'h00, 1'b0, 1'b0, 1'b1);
    do_req(`CMD_BCAST_WRITE, `EXT_NONE, FAR, 8'h00, 1'b0, 1'b0, 1'b1);
    do_req(`CMD_SEQ_WRITE, `EXT_PACKET_MASK, ADR, 8'h1B, 1'b1, 1'b1, 1'b1);
  end
  endtask
  task wrap_up;
  begin
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_refuse;
    t_table;
    t_masks;
    t_access;
    // 48 reserved combinations framed, last answer was a retry, framer idle
    apb(1'b0, `RPD_STAT_OFF, 32'h0);
    cmp(rd, 32'h0000_3004, "stat");
    wrap_up;
  end
endmodule  // request_packet_decoder_tb
